/* File: hw/ndd_host_ctrl.sv */
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ndd_cfg.svh"
module ndd_host_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chip_select_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  localparam logic [2:0] TWB = 3'(`NDD_TWB_CYC);
  localparam logic [2:0] ID_LAST = 3'(`NDD_ID_BYTES - 1);

  ndd_pkg::ndd_state_t state;
  ndd_pkg::ndd_op_t op;
  logic [4:0] idx;
  logic [1:0] ph;
  logic [2:0] tmr;
  logic [2:0] rcnt;
  logic [12:0] dcnt;
  logic fin;
  logic [5:0] page;
  logic [10:0] blk_a;
  logic [10:0] blk_b;
  logic [12:0] col;
  logic [7:0] fill;
  logic [12:0] dlen;
  logic [39:0] id_bytes;
  logic [7:0] ext_stat;
  logic err_dist;
  logic err_busy;
  logic rb_s1, rb_s2;
  logic [7:0] io_s1, io_s2;
  logic acc, wr_ctrl, go_req, dist_bad, start_ok;
  ndd_pkg::ndd_op_t req_op;
  logic [10:0] item;
  ndd_pkg::ndd_kind_t kind;
  logic [7:0] arg, obyte;
  logic [16:0] row_a, row_b;

  // Step table: each operation is a fixed list of bus cycles.
  function automatic logic [10:0] step_f(input ndd_pkg::ndd_op_t o, input logic [4:0] i);
    logic [7:0] key;
    key = {o, i};
    case (key)
      {ndd_pkg::NDD_OP_ID, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ID};
      {ndd_pkg::NDD_OP_ID, 5'h01}: step_f = {ndd_pkg::NDD_K_ADR, 8'h08};
      {ndd_pkg::NDD_OP_ID, 5'h02}: step_f = {ndd_pkg::NDD_K_RD, 8'h00};
      {ndd_pkg::NDD_OP_ERASE, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ERASE_SETUP};
      {ndd_pkg::NDD_OP_ERASE, 5'h01}: step_f = {ndd_pkg::NDD_K_ADR, 8'h02};
      {ndd_pkg::NDD_OP_ERASE, 5'h02}: step_f = {ndd_pkg::NDD_K_ADR, 8'h03};
      {ndd_pkg::NDD_OP_ERASE, 5'h03}: step_f = {ndd_pkg::NDD_K_ADR, 8'h04};
      {ndd_pkg::NDD_OP_ERASE, 5'h04}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ERASE_GO};
      {ndd_pkg::NDD_OP_ERASE, 5'h05}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_DERASE, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ERASE_SETUP};
      {ndd_pkg::NDD_OP_DERASE, 5'h01}: step_f = {ndd_pkg::NDD_K_ADR, 8'h02};
      {ndd_pkg::NDD_OP_DERASE, 5'h02}: step_f = {ndd_pkg::NDD_K_ADR, 8'h03};
      {ndd_pkg::NDD_OP_DERASE, 5'h03}: step_f = {ndd_pkg::NDD_K_ADR, 8'h04};
      {ndd_pkg::NDD_OP_DERASE, 5'h04}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ERASE_SETUP};
      {ndd_pkg::NDD_OP_DERASE, 5'h05}: step_f = {ndd_pkg::NDD_K_ADR, 8'h05};
      {ndd_pkg::NDD_OP_DERASE, 5'h06}: step_f = {ndd_pkg::NDD_K_ADR, 8'h06};
      {ndd_pkg::NDD_OP_DERASE, 5'h07}: step_f = {ndd_pkg::NDD_K_ADR, 8'h07};
      {ndd_pkg::NDD_OP_DERASE, 5'h08}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_ERASE_GO};
      {ndd_pkg::NDD_OP_DERASE, 5'h09}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_DATA_IN};
      {ndd_pkg::NDD_OP_DPROG, 5'h01}: step_f = {ndd_pkg::NDD_K_ADR, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h02}: step_f = {ndd_pkg::NDD_K_ADR, 8'h01};
      {ndd_pkg::NDD_OP_DPROG, 5'h03}: step_f = {ndd_pkg::NDD_K_ADR, 8'h02};
      {ndd_pkg::NDD_OP_DPROG, 5'h04}: step_f = {ndd_pkg::NDD_K_ADR, 8'h03};
      {ndd_pkg::NDD_OP_DPROG, 5'h05}: step_f = {ndd_pkg::NDD_K_ADR, 8'h04};
      {ndd_pkg::NDD_OP_DPROG, 5'h06}: step_f = {ndd_pkg::NDD_K_DAT, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h07}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_DUAL};
      {ndd_pkg::NDD_OP_DPROG, 5'h08}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h09}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_DATA_IN2};
      {ndd_pkg::NDD_OP_DPROG, 5'h0A}: step_f = {ndd_pkg::NDD_K_ADR, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h0B}: step_f = {ndd_pkg::NDD_K_ADR, 8'h01};
      {ndd_pkg::NDD_OP_DPROG, 5'h0C}: step_f = {ndd_pkg::NDD_K_ADR, 8'h05};
      {ndd_pkg::NDD_OP_DPROG, 5'h0D}: step_f = {ndd_pkg::NDD_K_ADR, 8'h06};
      {ndd_pkg::NDD_OP_DPROG, 5'h0E}: step_f = {ndd_pkg::NDD_K_ADR, 8'h07};
      {ndd_pkg::NDD_OP_DPROG, 5'h0F}: step_f = {ndd_pkg::NDD_K_DAT, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h10}: step_f = {ndd_pkg::NDD_K_FIN, 8'h00};
      {ndd_pkg::NDD_OP_DPROG, 5'h11}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_READ};
      {ndd_pkg::NDD_OP_COPY, 5'h01}: step_f = {ndd_pkg::NDD_K_ADR, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h02}: step_f = {ndd_pkg::NDD_K_ADR, 8'h01};
      {ndd_pkg::NDD_OP_COPY, 5'h03}: step_f = {ndd_pkg::NDD_K_ADR, 8'h02};
      {ndd_pkg::NDD_OP_COPY, 5'h04}: step_f = {ndd_pkg::NDD_K_ADR, 8'h03};
      {ndd_pkg::NDD_OP_COPY, 5'h05}: step_f = {ndd_pkg::NDD_K_ADR, 8'h04};
      {ndd_pkg::NDD_OP_COPY, 5'h06}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_READ_GO};
      {ndd_pkg::NDD_OP_COPY, 5'h07}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h08}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_COPY};
      {ndd_pkg::NDD_OP_COPY, 5'h09}: step_f = {ndd_pkg::NDD_K_ADR, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h0A}: step_f = {ndd_pkg::NDD_K_ADR, 8'h01};
      {ndd_pkg::NDD_OP_COPY, 5'h0B}: step_f = {ndd_pkg::NDD_K_ADR, 8'h05};
      {ndd_pkg::NDD_OP_COPY, 5'h0C}: step_f = {ndd_pkg::NDD_K_ADR, 8'h06};
      {ndd_pkg::NDD_OP_COPY, 5'h0D}: step_f = {ndd_pkg::NDD_K_ADR, 8'h07};
      {ndd_pkg::NDD_OP_COPY, 5'h0E}: step_f = {ndd_pkg::NDD_K_DAT, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h0F}: step_f = {ndd_pkg::NDD_K_FIN, 8'h00};
      {ndd_pkg::NDD_OP_COPY, 5'h10}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      {ndd_pkg::NDD_OP_XSTAT, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_XSTAT};
      {ndd_pkg::NDD_OP_XSTAT, 5'h01}: step_f = {ndd_pkg::NDD_K_RD, 8'h00};
      {ndd_pkg::NDD_OP_RST, 5'h00}: step_f = {ndd_pkg::NDD_K_CMD, `NDD_CMD_RESET};
      {ndd_pkg::NDD_OP_RST, 5'h01}: step_f = {ndd_pkg::NDD_K_WAIT, 8'h00};
      default: step_f = {ndd_pkg::NDD_K_END, 8'h00};
    endcase
  endfunction : step_f

  // Both rows share one page number; the district is the block's low bit.
  assign row_a = {blk_a, page};
  assign row_b = {blk_b, page};
  assign item = step_f(op, idx);
  assign kind = ndd_pkg::ndd_kind_t'(item[10:8]);
  assign arg = item[7:0];

  // Byte placed on the bus for the current step.
  always_comb begin
    case (kind)
      ndd_pkg::NDD_K_CMD: obyte = arg;
      ndd_pkg::NDD_K_FIN: obyte = fin ? `NDD_CMD_PROG : `NDD_CMD_CACHE;
      ndd_pkg::NDD_K_DAT: obyte = fill;
      ndd_pkg::NDD_K_ADR: begin
        case (arg)
          8'h00: obyte = col[7:0];
          8'h01: obyte = {3'h0, col[12:8]};
          8'h02: obyte = row_a[7:0];
          8'h03: obyte = row_a[15:8];
          8'h04: obyte = {7'h00, row_a[16]};
          8'h05: obyte = row_b[7:0];
          8'h06: obyte = row_b[15:8];
          8'h07: obyte = {7'h00, row_b[16]};
          default: obyte = 8'h00;
        endcase
      end
      default: obyte = 8'h00;
    endcase
  end

  // Request decode and the district checks made before anything is sent.
  assign acc = psel & penable & pready;
  assign wr_ctrl = acc & pwrite & (paddr == `NDD_REG_CTRL);
  assign req_op = ndd_pkg::ndd_op_t'(pwdata[`NDD_CTRL_OP_MSB:`NDD_CTRL_OP_LSB]);
  assign go_req = wr_ctrl & pwdata[`NDD_CTRL_GO] & ~pwdata[`NDD_CTRL_ABORT];
  assign dist_bad = (((req_op == ndd_pkg::NDD_OP_DPROG) || (req_op == ndd_pkg::NDD_OP_DERASE))
                     && (blk_a[0] == blk_b[0]))
                    || ((req_op == ndd_pkg::NDD_OP_COPY) && (blk_a[0] != blk_b[0]));
  assign start_ok = go_req & (state == ndd_pkg::NDD_S_IDLE) & ~dist_bad;

  // Ready and data pins cross in through two flip-flops.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
    end else if (ce) begin
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end

  // APB slave: two-cycle access phase, unmapped offsets read zero with an error.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & penable & ~pready) begin
        case (paddr)
          `NDD_REG_CTRL: prdata <= {31'h0, fin} << `NDD_CTRL_FINAL;
          `NDD_REG_ADDR_A: prdata <= {15'h0, blk_a, page};
          `NDD_REG_ADDR_B: prdata <= {21'h0, blk_b};
          `NDD_REG_COL: prdata <= {19'h0, col};
          `NDD_REG_DATA: prdata <= {3'h0, dlen, 8'h00, fill};
          `NDD_REG_STATUS: prdata <= {16'h0, ext_stat, 4'h0, err_busy, err_dist, rb_s2,
                                      state != ndd_pkg::NDD_S_IDLE};
          `NDD_REG_ID_LO: prdata <= id_bytes[39:8];
          `NDD_REG_ID_HI: prdata <= {24'h0, id_bytes[7:0]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Software-written address and data settings.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      page <= 6'h00;
      blk_a <= 11'h000;
      blk_b <= 11'h001;
      col <= 13'h0000;
      fill <= 8'hFF;
      dlen <= 13'h0000;
    end else if (ce && acc && pwrite) begin
      case (paddr)
        `NDD_REG_ADDR_A: {blk_a, page} <= pwdata[16:0];
        `NDD_REG_ADDR_B: blk_b <= pwdata[10:0];
        `NDD_REG_COL: col <= pwdata[12:0];
        `NDD_REG_DATA: {dlen, fill} <= {pwdata[28:16], pwdata[7:0]};
        default: ;
      endcase
    end
  end

  // Sticky refusal flags; a new refusal wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_dist <= 1'b0;
      err_busy <= 1'b0;
    end else if (ce) begin
      if (acc && pwrite && (paddr == `NDD_REG_STATUS)) begin
        err_dist <= err_dist & ~pwdata[`NDD_ST_ERR_DIST];
        err_busy <= err_busy & ~pwdata[`NDD_ST_ERR_BUSY];
      end
      if (go_req && (state == ndd_pkg::NDD_S_IDLE) && dist_bad) begin
        err_dist <= 1'b1;
      end
      if (go_req && (state != ndd_pkg::NDD_S_IDLE)) begin
        err_busy <= 1'b1;
      end
    end
  end

  // Sequencer: each write bus cycle is latch setup, strobe low, strobe high, release; a read holds its strobe low for three cycles.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ndd_pkg::NDD_S_IDLE;
      op <= ndd_pkg::NDD_OP_ID;
      idx <= 5'h00;
      ph <= 2'h0;
      tmr <= 3'h0;
      rcnt <= 3'h0;
      dcnt <= 13'h0000;
      fin <= 1'b1;
      chip_select_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_protect_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      id_bytes <= 40'h00_0000_0000;
      ext_stat <= 8'h00;
    end else if (ce) begin
      if (wr_ctrl && pwdata[`NDD_CTRL_ABORT]) begin
        op <= ndd_pkg::NDD_OP_RST;
        state <= ndd_pkg::NDD_S_RUN;
        {idx, ph, rcnt, dcnt} <= 23'h00_0000;
        // Latches stay put so that a write strobe in flight rises with them held.
        {write_strobe_n, read_strobe_n, chip_select_n} <= 3'b110;
      end else if (start_ok) begin
        op <= req_op;
        fin <= pwdata[`NDD_CTRL_FINAL];
        state <= ndd_pkg::NDD_S_RUN;
        {idx, ph, rcnt, dcnt} <= 23'h00_0000;
        chip_select_n <= 1'b0;
        write_protect_n <= 1'b1;
      end else begin
        case (state)
          ndd_pkg::NDD_S_RUN: begin
            case (kind)
              ndd_pkg::NDD_K_CMD, ndd_pkg::NDD_K_ADR, ndd_pkg::NDD_K_DAT, ndd_pkg::NDD_K_FIN: begin
                if ((kind == ndd_pkg::NDD_K_DAT) && (dcnt == dlen)) begin
                  dcnt <= 13'h0000;
                  idx <= idx + 5'h01;
                end else begin
                  ph <= ph + 2'h1;
                  case (ph)
                    2'h0: begin
                      cmd_latch <= (kind == ndd_pkg::NDD_K_CMD) || (kind == ndd_pkg::NDD_K_FIN);
                      addr_latch <= (kind == ndd_pkg::NDD_K_ADR);
                      io_out <= obyte;
                      io_oe <= 1'b1;
                    end
                    2'h1: write_strobe_n <= 1'b0;
                    2'h2: write_strobe_n <= 1'b1;
                    default: begin
                      cmd_latch <= 1'b0;
                      addr_latch <= 1'b0;
                      if (kind == ndd_pkg::NDD_K_DAT) begin
                        dcnt <= dcnt + 13'h0001;
                      end else begin
                        idx <= idx + 5'h01;
                      end
                    end
                  endcase
                end
              end
              ndd_pkg::NDD_K_RD: begin
                ph <= ph + 2'h1;
                if (ph == 2'h0) begin
                  read_strobe_n <= 1'b0;
                  io_oe <= 1'b0;
                end else if (ph == 2'h3) begin
                  read_strobe_n <= 1'b1;
                  if (op == ndd_pkg::NDD_OP_ID) begin
                    id_bytes <= {id_bytes[31:0], io_s2};
                  end else begin
                    ext_stat <= io_s2;
                  end
                  if ((op != ndd_pkg::NDD_OP_ID) || (rcnt == ID_LAST)) begin
                    rcnt <= 3'h0;
                    idx <= idx + 5'h01;
                  end else begin
                    rcnt <= rcnt + 3'h1;
                  end
                end
              end
              ndd_pkg::NDD_K_WAIT: begin
                io_oe <= 1'b0;
                tmr <= TWB;
                idx <= idx + 5'h01;
                state <= ndd_pkg::NDD_S_WAIT;
              end
              default: begin
                state <= ndd_pkg::NDD_S_IDLE;
                chip_select_n <= 1'b1;
                write_protect_n <= 1'b0;
                io_oe <= 1'b0;
              end
            endcase
          end
          ndd_pkg::NDD_S_WAIT: begin
            if (tmr != 3'h0) begin
              tmr <= tmr - 3'h1;
            end else if (rb_s2) begin
              state <= ndd_pkg::NDD_S_RUN;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Checks on the pin sequences and refusals.
  strobe_setup_a: assert property (@(posedge clk) disable iff (!nrst)
    !write_strobe_n |-> (cmd_latch != addr_latch || !cmd_latch) && io_oe && $past(io_oe))
    else $error("Write strobe without stable latch and data drive.");
  erase_confirm_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
    (!write_strobe_n && cmd_latch && io_out == `NDD_CMD_ERASE_GO)
    |-> ##[1:6] state == ndd_pkg::NDD_S_WAIT)
    else $error("Erase confirm not followed by a busy wait.");
  district_refuse_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
    (go_req && state == ndd_pkg::NDD_S_IDLE && dist_bad)
    |=> state == ndd_pkg::NDD_S_IDLE && err_dist)
    else $error("Bad district pair was not refused.");
  busy_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    state == ndd_pkg::NDD_S_WAIT |-> write_strobe_n && !cmd_latch && !addr_latch)
    else $error("Bus cycle issued while waiting on busy.");
  wp_high_a: assert property (@(posedge clk) disable iff (!nrst)
    state != ndd_pkg::NDD_S_IDLE && op != ndd_pkg::NDD_OP_RST |-> write_protect_n)
    else $error("Write protect low during an operation.");
  cache_final_a: assert property (@(posedge clk) disable iff (!nrst)
    (!write_strobe_n && cmd_latch && io_out == `NDD_CMD_CACHE) |-> !fin)
    else $error("Cache command sent on a final step.");
  abort_reset_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
    (wr_ctrl && pwdata[`NDD_CTRL_ABORT])
    |=> state == ndd_pkg::NDD_S_RUN && op == ndd_pkg::NDD_OP_RST && idx == 5'h00)
    else $error("Abort did not start a reset command.");
  read_pulse_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
    $fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n)
    else $error("Read strobe low time is not three cycles.");
  busy_hold_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
    (state == ndd_pkg::NDD_S_WAIT && $past(state) != ndd_pkg::NDD_S_WAIT)
    |-> state == ndd_pkg::NDD_S_WAIT [*3])
    else $error("Busy wait shorter than the write-to-busy gap.");
  apb_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");
endmodule : ndd_host_ctrl
`default_nettype wire

/* File: hw/ndd_cfg.svh */
`ifndef NDD_CFG_SVH
`define NDD_CFG_SVH
// Register offsets of the controller's own APB map.
`define NDD_REG_CTRL 8'h00
`define NDD_REG_ADDR_A 8'h04
`define NDD_REG_ADDR_B 8'h08
`define NDD_REG_COL 8'h0C
`define NDD_REG_DATA 8'h10
`define NDD_REG_STATUS 8'h14
`define NDD_REG_ID_LO 8'h18
`define NDD_REG_ID_HI 8'h1C
// Control register fields.
`define NDD_CTRL_GO 0
`define NDD_CTRL_OP_LSB 1
`define NDD_CTRL_OP_MSB 3
`define NDD_CTRL_FINAL 4
`define NDD_CTRL_ABORT 5
// Status register fields.
`define NDD_ST_BUSY 0
`define NDD_ST_READY 1
`define NDD_ST_ERR_DIST 2
`define NDD_ST_ERR_BUSY 3
`define NDD_ST_EXT_LSB 8
// Extended status byte fields as read back from the device.
`define NDD_EXT_FAIL_ANY 0
`define NDD_EXT_PB_READY 5
`define NDD_EXT_CACHE_READY 6
`define NDD_EXT_WP 7
// Device command codes.
`define NDD_CMD_READ 8'h00
`define NDD_CMD_READ_GO 8'h30
`define NDD_CMD_ID 8'h90
`define NDD_CMD_ERASE_SETUP 8'h60
`define NDD_CMD_ERASE_GO 8'hD0
`define NDD_CMD_DATA_IN 8'h80
`define NDD_CMD_DATA_IN2 8'h81
`define NDD_CMD_DUAL 8'h11
`define NDD_CMD_COPY 8'h8C
`define NDD_CMD_PROG 8'h10
`define NDD_CMD_CACHE 8'h15
`define NDD_CMD_XSTAT 8'h71
`define NDD_CMD_RESET 8'hFF
// Timing: clock rate and the write-to-busy gap, rounded up to cycles.
`define NDD_CLK_MHZ 20
`define NDD_TWB_NS 100
`define NDD_TWB_CYC ((`NDD_TWB_NS * `NDD_CLK_MHZ + 999) / 1000)
`define NDD_ID_BYTES 5
`endif

/* File: hw/ndd_pkg.sv */
package ndd_pkg;
  typedef enum logic [1:0] {
    NDD_S_IDLE = 2'b00,
    NDD_S_RUN = 2'b01,
    NDD_S_WAIT = 2'b10
  } ndd_state_t;
  typedef enum logic [2:0] {
    NDD_OP_ID = 3'b000,
    NDD_OP_ERASE = 3'b001,
    NDD_OP_DERASE = 3'b010,
    NDD_OP_DPROG = 3'b011,
    NDD_OP_COPY = 3'b100,
    NDD_OP_XSTAT = 3'b101,
    NDD_OP_RST = 3'b110
  } ndd_op_t;
  typedef enum logic [2:0] {
    NDD_K_CMD = 3'b000,
    NDD_K_ADR = 3'b001,
    NDD_K_DAT = 3'b010,
    NDD_K_RD = 3'b011,
    NDD_K_WAIT = 3'b100,
    NDD_K_END = 3'b101,
    NDD_K_FIN = 3'b110
  } ndd_kind_t;
endpackage : ndd_pkg

/* File: sim/ndd_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ndd_dev_model #(
  parameter logic [7:0] MAKER = 8'h5A,
  parameter logic [7:0] DEVICE = 8'hA7
) (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic cl,
  input wire logic al,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic rb_n
);
  // MAKER and DEVICE defaults are arbitrary values.
  localparam logic [7:0] ID_B [5] = '{MAKER, DEVICE, 8'h90, 8'h26, 8'h76};
  logic [9:0] log_q[$];
  logic [7:0] cmd = 8'h00;
  logic [1:0] fail = 2'b00;
  logic wp_bad = 1'b0;
  logic [7:0] ext;
  int idx = 0, cyc = 0, bz = 0, hold = 0;
  initial dout = 8'h00;
  initial rb_n = 1'b1;
  assign ext = {3'b111, 2'b00, fail, |fail};
  // Every latched byte is logged; confirm commands start a busy time.
  always @(posedge we_n) if (!cs_n) begin
    log_q.push_back({cl, al, din});
    if (!wp_n) wp_bad = 1'b1;
    if (cl) begin
      cmd = din;
      idx = 0;
      if (din inside {8'h30, 8'hD0, 8'h10, 8'h15, 8'h11, 8'hFF}) bz = cyc + 20;
    end
  end
  // Each read strobe moves to the next byte.
  always @(posedge re_n) idx = idx + 1;
  // The busy time is counted in clock cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rb_n <= (cyc >= bz);
  end
  // Data follows the falling read strobe at once, holds while it is low and two cycles after it rises, then toggles.
  always @(posedge clk or negedge re_n) begin
    if (!re_n) begin
      dout <= (cmd == 8'h71) ? ext : ID_B[idx % 5];
      hold <= 2;
    end else if (hold != 0) hold <= hold - 1;
    else dout <= ~dout;
  end
endmodule : ndd_dev_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ndd_cfg.svh"
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, cs_n, cl, al, we_n, re_n, wp_n, io_oe, rb_n;
  logic [7:0] io_out, io_in, fill;
  logic [64:0] exp_q[$], nt;
  logic [9:0] elog[$];
  logic [10:0] ba, bb;
  logic [5:0] pg;
  logic [1:0] fl;
  logic [12:0] col;
  int bad_count = 0, n_checks = 0, seed = 83, cyc = 0;
  initial forever #25 clk = ~clk;
  ndd_host_ctrl DUT (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_select_n(cs_n), .cmd_latch(cl), .addr_latch(al),
    .write_strobe_n(we_n), .read_strobe_n(re_n), .write_protect_n(wp_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(rb_n));
  ndd_dev_model dev (.clk(clk), .cs_n(cs_n), .cl(cl), .al(al), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .din(io_out), .dout(io_in), .rb_n(rb_n));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // One APB transfer; the expected answer is noted before it starts.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, m,
                     input logic er);
    exp_q.push_back({m, er, e});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd
  task automatic op(input ndd_pkg::ndd_op_t o, input logic f);
    wr(`NDD_REG_CTRL, {27'h0, f, o, 1'b1});
    do rd(`NDD_REG_STATUS, 32'h0, 32'h0); while (r[0] !== 1'b0);
  endtask : op
  task automatic ex(input logic [1:0] k, input logic [7:0] b);
    elog.push_back({k, b});
  endtask : ex
  task automatic erow(input logic [16:0] w);
    ex(2'd1, w[7:0]);
    ex(2'd1, w[15:8]);
    ex(2'd1, {7'h0, w[16]});
  endtask : erow
  task automatic ecol;
    ex(2'd1, col[7:0]);
    ex(2'd1, {3'h0, col[12:8]});
  endtask : ecol
  task automatic cmp_log;
    chk("log size", 32'(elog.size()), 32'(dev.log_q.size()));
    foreach (elog[i]) chk("log byte", {22'h0, elog[i]}, {22'h0, dev.log_q[i]});
    elog.delete();
    dev.log_q.delete();
  endtask : cmp_log
  // Each answered transfer is compared with the oldest note.
  always @(posedge clk) if (psel && penable && pready === 1'b1) begin
    nt = exp_q.pop_front();
    chk("prdata", nt[31:0] & nt[64:33], prdata & nt[64:33]);
    chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
  end
  // A hang is cut short here.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`NDD_REG_ADDR_B, 32'h1, '1);
    rd(`NDD_REG_STATUS, 32'h2, 32'hF);
    apb(1'b0, 8'h20, 32'h0, 32'h0, '1, 1'b1);
    r = $random(seed);
    ba = {r[10:1], 1'b0};
    bb = {r[20:11], 1'b1};
    pg = r[26:21];
    r = $random(seed);
    col = r[12:0];
    fill = r[20:13];
    fl = r[22:21];
    wr(`NDD_REG_ADDR_A, {15'h0, ba, pg});
    wr(`NDD_REG_ADDR_B, {21'h0, bb});
    wr(`NDD_REG_COL, {19'h0, col});
    wr(`NDD_REG_DATA, {16'h2, 8'h0, fill});
    $display("test reset done");
    ex(2'd2, 8'h90);
    ex(2'd1, 8'h00);
    op(ndd_pkg::NDD_OP_ID, 1'b0);
    cmp_log();
    rd(`NDD_REG_ID_LO, {dev.MAKER, dev.DEVICE, 8'h90, 8'h26}, '1);
    rd(`NDD_REG_ID_HI, 32'h76, '1);
    ex(2'd2, 8'h60);
    erow({ba, pg});
    ex(2'd2, 8'hD0);
    op(ndd_pkg::NDD_OP_ERASE, 1'b0);
    cmp_log();
    ex(2'd2, 8'h60);
    erow({ba, pg});
    ex(2'd2, 8'h60);
    erow({bb, pg});
    ex(2'd2, 8'hD0);
    op(ndd_pkg::NDD_OP_DERASE, 1'b0);
    cmp_log();
    wr(`NDD_REG_ADDR_B, {21'h0, ba ^ 11'h2});
    op(ndd_pkg::NDD_OP_DERASE, 1'b0);
    cmp_log();
    rd(`NDD_REG_STATUS, 32'h4, 32'h4);
    wr(`NDD_REG_STATUS, 32'hC);
    $display("test erase done");
    wr(`NDD_REG_ADDR_B, {21'h0, bb});
    ex(2'd2, 8'h80);
    ecol();
    erow({ba, pg});
    ex(2'd0, fill);
    ex(2'd0, fill);
    ex(2'd2, 8'h11);
    ex(2'd2, 8'h81);
    ecol();
    erow({bb, pg});
    ex(2'd0, fill);
    ex(2'd0, fill);
    ex(2'd2, 8'h10);
    op(ndd_pkg::NDD_OP_DPROG, 1'b1);
    cmp_log();
    wr(`NDD_REG_ADDR_B, {21'h0, ba ^ 11'h2});
    wr(`NDD_REG_DATA, {24'h0, fill});
    ex(2'd2, 8'h00);
    ecol();
    erow({ba, pg});
    ex(2'd2, 8'h30);
    ex(2'd2, 8'h8C);
    ecol();
    erow({ba ^ 11'h2, pg});
    ex(2'd2, 8'h10);
    op(ndd_pkg::NDD_OP_COPY, 1'b1);
    cmp_log();
    chk("write protect", 32'h0, {31'h0, dev.wp_bad});
    $display("test program copy done");
    dev.fail = fl;
    ex(2'd2, 8'h71);
    op(ndd_pkg::NDD_OP_XSTAT, 1'b0);
    cmp_log();
    rd(`NDD_REG_STATUS, {16'h0, 3'b111, 2'b00, fl, |fl, 8'h0}, 32'hFF00);
    ex(2'd2, 8'h60);
    erow({ba, pg});
    ex(2'd2, 8'hD0);
    wr(`NDD_REG_CTRL, 32'h3);
    op(ndd_pkg::NDD_OP_ID, 1'b0);
    rd(`NDD_REG_STATUS, 32'h8, 32'h8);
    cmp_log();
    wr(`NDD_REG_STATUS, 32'hC);
    wr(`NDD_REG_ADDR_B, {21'h0, bb});
    wr(`NDD_REG_CTRL, 32'h5);
    wr(`NDD_REG_CTRL, 32'h20);
    do rd(`NDD_REG_STATUS, 32'h0, 32'h0); while (r[0] !== 1'b0);
    chk("abort cmd", 32'h2FF, {22'h0, dev.log_q[$]});
    chk("abort short", 32'h1, {31'h0, dev.log_q.size() < 9});
    dev.log_q.delete();
    ex(2'd2, 8'hFF);
    op(ndd_pkg::NDD_OP_RST, 1'b0);
    cmp_log();
    $display("test status abort done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
